// File: rtl/boot_seq_pkg.sv
package boot_seq_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_FREQ_HZ = 20000000;
  localparam int RESET_PROC_MIN_US = 15;
  localparam int RESET_PROC_CYCLES =
    (RESET_PROC_MIN_US * CLK_FREQ_HZ + 999999) / 1000000;

  // ----------------------------------------
  // Image format constants
  // ----------------------------------------
  localparam logic [31:0] CRC_SKIP_WORD = 32'h0d15ab1e;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_PRESET = 32'hffffffff;
  localparam logic [31:0] NULL_ACK_CHAN = 32'h0000ff02;
  localparam int SECURE_BOOT_BIT = 5;

  // ----------------------------------------
  // PLL reset values
  // ----------------------------------------
  localparam logic [2:0] PLL_OD_RESET = 3'h1;
  localparam logic [11:0] PLL_F_RESET = 12'h03f;
  localparam logic [5:0] PLL_R_RESET = 6'h00;

  // ----------------------------------------
  // Boot sources and link sets
  // ----------------------------------------
  typedef enum logic [2:0] {
    SRC_QSPI_MASTER = 3'h0,
    SRC_SPI_MASTER = 3'h1,
    SRC_SPI_SLAVE = 3'h2,
    SRC_CHAN_END0 = 3'h3,
    SRC_OTP = 3'h4
  } boot_src_type;

  localparam logic [7:0] LINKS_NONE = 8'h00;
  localparam logic [7:0] LINKS_ZERO_2W = 8'h01;
  localparam logic [7:0] LINKS_4_7 = 8'hf0;
  localparam logic [7:0] LINKS_1256 = 8'h66;
  localparam logic [7:0] LINKS_0_3 = 8'h0f;

  typedef struct packed {
    boot_src_type tile0_src;
    boot_src_type tile1_src;
    logic [7:0] links_en;
    logic links_five_wire;
  } boot_sel_type;

  typedef struct packed {
    logic [2:0] pll_output_divider;
    logic [11:0] feedback;
    logic [5:0] ref_divider;
  } pll_cfg_type;

  // ----------------------------------------
  // Loader states, Gray coded along the path
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_INTRST = 3'b001,
    ST_ACK = 3'b011,
    ST_LEN = 3'b010,
    ST_PROG = 3'b110,
    ST_CHECK = 3'b111,
    ST_RUN = 3'b101,
    ST_ERROR = 3'b100
  } load_state_type;

endpackage

// File: rtl/crc32_byte.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// One byte step of the reflected CRC-32
// ----------------------------------------
module crc32_byte
(
  input wire logic [31:0] crc_in,
  input wire logic [7:0] data,
  output logic [31:0] crc_out
);

  // Bitwise LSB-first loop; eight xor/shift stages per byte
  always_comb
  begin
    logic [31:0] c;
    c = crc_in;
    for (int i = 0; i < 8; i++)
    begin
      if (c[0] ^ data[i])
        c = (c >> 1) ^ boot_seq_pkg::CRC_POLY;
      else
        c = c >> 1;
    end
    crc_out = c;
  end

endmodule

`default_nettype wire

// File: rtl/tile_boot_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module tile_boot_sequencer
#(
  parameter int ADDR_W = 16
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rst_n_pin,
  input wire logic boot_strap_bit0,
  input wire logic boot_strap_bit1,
  input wire logic boot_strap_bit2,
  input wire logic [31:0] security_reg,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready_ff,
  output logic gpio_pull_down_ff,
  output logic core_reset_ff,
  output logic boot_start_ff,
  output boot_seq_pkg::boot_sel_type boot_sel_ff,
  output logic otp_fetch_ff,
  output logic [ADDR_W-1:0] fetch_addr_ff,
  output logic ram_we_ff,
  output logic [ADDR_W-1:0] ram_addr_ff,
  output logic [7:0] ram_wdata_ff,
  output logic [31:0] ack_chan_ff,
  output logic send_ack_ff,
  output logic run_ff,
  output logic [ADDR_W-1:0] run_addr_ff,
  output logic boot_error_ff,
  output boot_seq_pkg::pll_cfg_type pll_cfg_ff
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] rstn_sync_ff;
  logic [2:0] strap_meta_ff;
  logic [2:0] strap_sync_ff;

  // Reset pin and straps come from outside, two flops each
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rstn_sync_ff <= 2'h0;
      strap_meta_ff <= 3'h0;
      strap_sync_ff <= 3'h0;
    end
    else
    begin
      rstn_sync_ff <= {rstn_sync_ff[0], rst_n_pin};
      strap_meta_ff <= {boot_strap_bit2, boot_strap_bit1, boot_strap_bit0};
      strap_sync_ff <= strap_meta_ff;
    end
  end

  logic pin_low;
  assign pin_low = ~rstn_sync_ff[1];

  // ----------------------------------------
  // Strap decode
  // ----------------------------------------
  boot_seq_pkg::boot_sel_type nxt_sel;
  logic secure;
  assign secure = security_reg[boot_seq_pkg::SECURE_BOOT_BIT];

  always_comb
  begin
    nxt_sel.links_five_wire = 1'b0;
    nxt_sel.links_en = boot_seq_pkg::LINKS_NONE;
    nxt_sel.tile1_src = boot_seq_pkg::SRC_CHAN_END0;
    nxt_sel.tile0_src = boot_seq_pkg::SRC_CHAN_END0;
    case (strap_sync_ff)
      3'h0: nxt_sel.tile0_src = boot_seq_pkg::SRC_QSPI_MASTER;
      3'h1: nxt_sel.tile0_src = boot_seq_pkg::SRC_SPI_MASTER;
      3'h2: nxt_sel.tile0_src = boot_seq_pkg::SRC_SPI_SLAVE;
      3'h3:
      begin
        nxt_sel.tile0_src = boot_seq_pkg::SRC_SPI_SLAVE;
        nxt_sel.tile1_src = boot_seq_pkg::SRC_SPI_SLAVE;
      end
      3'h4: nxt_sel.links_en = boot_seq_pkg::LINKS_ZERO_2W;
      3'h5:
      begin
        nxt_sel.links_en = boot_seq_pkg::LINKS_4_7;
        nxt_sel.links_five_wire = 1'b1;
      end
      3'h6:
      begin
        nxt_sel.links_en = boot_seq_pkg::LINKS_1256;
        nxt_sel.links_five_wire = 1'b1;
      end
      default:
      begin
        nxt_sel.links_en = boot_seq_pkg::LINKS_0_3;
        nxt_sel.links_five_wire = 1'b1;
      end
    endcase
    // Secure boot overrides the straps for both tiles
    if (secure)
    begin
      nxt_sel.tile0_src = boot_seq_pkg::SRC_OTP;
      nxt_sel.tile1_src = boot_seq_pkg::SRC_OTP;
    end
  end

  // ----------------------------------------
  // Loader state machine
  // ----------------------------------------
  boot_seq_pkg::load_state_type state_ff;
  logic [15:0] wait_cnt_ff;
  logic [1:0] byte_idx_ff;
  logic [31:0] word_ff;
  logic [31:0] words_left_ff;
  logic [31:0] crc_ff;
  logic [31:0] nxt_crc;
  logic [31:0] nxt_word;
  logic take;
  logic word_done;

  localparam logic [15:0] WAIT_LAST =
    16'(boot_seq_pkg::RESET_PROC_CYCLES - 1);

  assign take = byte_valid && byte_ready_ff;
  assign word_done = take && (byte_idx_ff == 2'h3);
  // Bytes enter at the top and shift down, so the first ends in bits 7:0, LSB first
  assign nxt_word = {byte_data, word_ff[31:8]};

  crc32_byte u_crc
  (
    .crc_in(crc_ff),
    .data(byte_data),
    .crc_out(nxt_crc)
  );

  // Sequencing; any low on the reset pin restarts everything
  always_ff @(posedge clk_sys)
  begin
    if (rst || pin_low)
      state_ff <= boot_seq_pkg::ST_RESET;
    else
    begin
      case (state_ff)
        boot_seq_pkg::ST_RESET:
          state_ff <= boot_seq_pkg::ST_INTRST;
        boot_seq_pkg::ST_INTRST:
          if (wait_cnt_ff == WAIT_LAST)
            state_ff <= (nxt_sel.tile0_src == boot_seq_pkg::SRC_CHAN_END0)
              ? boot_seq_pkg::ST_ACK : boot_seq_pkg::ST_LEN;
        boot_seq_pkg::ST_ACK:
          if (word_done)
            state_ff <= boot_seq_pkg::ST_LEN;
        boot_seq_pkg::ST_LEN:
          if (word_done)
            state_ff <= (nxt_word == 32'h0) ? boot_seq_pkg::ST_CHECK
              : boot_seq_pkg::ST_PROG;
        boot_seq_pkg::ST_PROG:
          if (word_done && words_left_ff == 32'h1)
            state_ff <= boot_seq_pkg::ST_CHECK;
        boot_seq_pkg::ST_CHECK:
          if (word_done)
          begin
            if (nxt_word == boot_seq_pkg::CRC_SKIP_WORD ||
                nxt_word == ~crc_ff)
              state_ff <= boot_seq_pkg::ST_RUN;
            else
              state_ff <= boot_seq_pkg::ST_ERROR;
          end
        boot_seq_pkg::ST_RUN:
          state_ff <= boot_seq_pkg::ST_RUN;
        boot_seq_pkg::ST_ERROR:
          state_ff <= boot_seq_pkg::ST_ERROR;
        default:
          state_ff <= boot_seq_pkg::ST_RESET;
      endcase
    end
  end

  // Internal reset timer, 15 us minimum at this clock
  always_ff @(posedge clk_sys)
  begin
    if (rst || pin_low || state_ff != boot_seq_pkg::ST_INTRST)
      wait_cnt_ff <= 16'h0;
    else if (wait_cnt_ff != WAIT_LAST)
      wait_cnt_ff <= wait_cnt_ff + 16'h1;
  end

  // Strap latch happens once when the internal reset ends
  always_ff @(posedge clk_sys)
  begin
    if (rst || pin_low)
      boot_sel_ff <= '0;
    else if (state_ff == boot_seq_pkg::ST_INTRST && wait_cnt_ff == WAIT_LAST)
      boot_sel_ff <= nxt_sel;
  end

  // ----------------------------------------
  // Byte assembly, counts and CRC
  // ----------------------------------------
  logic loading;
  assign loading = (state_ff == boot_seq_pkg::ST_ACK) ||
    (state_ff == boot_seq_pkg::ST_LEN) ||
    (state_ff == boot_seq_pkg::ST_PROG) ||
    (state_ff == boot_seq_pkg::ST_CHECK);

  // Ready registered; it drops on the edge that takes the check word so a byte offered
  // right after the check word is simply not taken
  always_ff @(posedge clk_sys)
  begin
    if (rst || pin_low)
      byte_ready_ff <= 1'b0;
    else
      byte_ready_ff <= loading &&
        !(state_ff == boot_seq_pkg::ST_CHECK && word_done);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || pin_low || !loading)
    begin
      byte_idx_ff <= 2'h0;
      word_ff <= 32'h0;
    end
    else if (take)
    begin
      byte_idx_ff <= byte_idx_ff + 2'h1;
      word_ff <= nxt_word;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || pin_low)
      words_left_ff <= 32'h0;
    else if (state_ff == boot_seq_pkg::ST_LEN && word_done)
      words_left_ff <= nxt_word;
    else if (state_ff == boot_seq_pkg::ST_PROG && word_done)
      words_left_ff <= words_left_ff - 32'h1;
  end

  // CRC runs over length and program, never the check word
  always_ff @(posedge clk_sys)
  begin
    if (rst || pin_low || state_ff == boot_seq_pkg::ST_ACK ||
        state_ff == boot_seq_pkg::ST_INTRST)
      crc_ff <= boot_seq_pkg::CRC_PRESET;
    else if (take && (state_ff == boot_seq_pkg::ST_LEN ||
             state_ff == boot_seq_pkg::ST_PROG))
      crc_ff <= nxt_crc;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || pin_low)
      ack_chan_ff <= boot_seq_pkg::NULL_ACK_CHAN;
    else if (state_ff == boot_seq_pkg::ST_ACK && word_done)
      ack_chan_ff <= nxt_word;
  end

  // ----------------------------------------
  // RAM write port
  // ----------------------------------------
  // Address advances after each write, from zero
  always_ff @(posedge clk_sys)
  begin
    if (rst || pin_low)
    begin
      ram_we_ff <= 1'b0;
      ram_addr_ff <= '0;
      ram_wdata_ff <= 8'h0;
    end
    else
    begin
      ram_we_ff <= take && state_ff == boot_seq_pkg::ST_PROG;
      ram_wdata_ff <= byte_data;
      if (ram_we_ff)
        ram_addr_ff <= ram_addr_ff + 1'b1;
    end
  end

  // ----------------------------------------
  // Status and control outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst || pin_low)
    begin
      gpio_pull_down_ff <= 1'b1;
      core_reset_ff <= 1'b1;
      boot_start_ff <= 1'b0;
      otp_fetch_ff <= 1'b0;
      fetch_addr_ff <= '0;
      run_ff <= 1'b0;
      run_addr_ff <= '0;
      boot_error_ff <= 1'b0;
      send_ack_ff <= 1'b0;
    end
    else
    begin
      gpio_pull_down_ff <= state_ff == boot_seq_pkg::ST_INTRST;
      core_reset_ff <= state_ff == boot_seq_pkg::ST_INTRST;
      boot_start_ff <= loading || boot_start_ff;
      otp_fetch_ff <= loading && boot_sel_ff.tile0_src ==
        boot_seq_pkg::SRC_OTP;
      fetch_addr_ff <= '0;
      run_ff <= state_ff == boot_seq_pkg::ST_RUN;
      run_addr_ff <= '0;
      boot_error_ff <= state_ff == boot_seq_pkg::ST_ERROR;
      send_ack_ff <= state_ff == boot_seq_pkg::ST_CHECK && word_done &&
        boot_sel_ff.tile0_src == boot_seq_pkg::SRC_CHAN_END0 &&
        ack_chan_ff != boot_seq_pkg::NULL_ACK_CHAN;
    end
  end

  // PLL settings take their reset values; F_core = F_osc*(F+1)/2
  // /(R+1)/(OD+1); the values then hold with no write path
  always_ff @(posedge clk_sys)
  begin
    if (rst || pin_low)
    begin
      pll_cfg_ff.pll_output_divider <= boot_seq_pkg::PLL_OD_RESET;
      pll_cfg_ff.feedback <= boot_seq_pkg::PLL_F_RESET;
      pll_cfg_ff.ref_divider <= boot_seq_pkg::PLL_R_RESET;
    end
    else
      pll_cfg_ff <= pll_cfg_ff;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_reset_holds: assert property (@(posedge clk_sys) disable iff (rst)
    pin_low |=> core_reset_ff && gpio_pull_down_ff)
    else $error("core not held in reset");

  a_no_run_error: assert property (@(posedge clk_sys) disable iff (rst)
    boot_error_ff |-> !run_ff)
    else $error("run with boot error");

  a_skip_word_runs: assert property (@(posedge clk_sys)
    disable iff (rst || pin_low)
    state_ff == boot_seq_pkg::ST_CHECK && word_done &&
    nxt_word == boot_seq_pkg::CRC_SKIP_WORD
    |=> state_ff == boot_seq_pkg::ST_RUN)
    else $error("skip word did not run");

  a_sel_stable: assert property (@(posedge clk_sys)
    disable iff (rst || pin_low)
    run_ff |-> $stable(boot_sel_ff))
    else $error("boot selection changed");

  a_secure_otp: assert property (@(posedge clk_sys)
    disable iff (rst || pin_low)
    state_ff == boot_seq_pkg::ST_INTRST && wait_cnt_ff == WAIT_LAST &&
    secure |=> boot_sel_ff.tile0_src == boot_seq_pkg::SRC_OTP)
    else $error("secure boot not honoured");

  a_first_write_zero: assert property (@(posedge clk_sys)
    disable iff (rst || pin_low)
    $rose(state_ff == boot_seq_pkg::ST_PROG) |->
    ram_addr_ff == '0 && !ram_we_ff)
    else $error("load not at lowest address");

  a_crc_preset: assert property (@(posedge clk_sys)
    disable iff (rst || pin_low)
    $rose(state_ff == boot_seq_pkg::ST_LEN) |->
    crc_ff == boot_seq_pkg::CRC_PRESET)
    else $error("crc not preset");

  a_wait_min: assert property (@(posedge clk_sys)
    disable iff (rst || pin_low)
    $rose(state_ff == boot_seq_pkg::ST_INTRST) |->
    !loading [*8])
    else $error("boot began too early");

endmodule

`default_nettype wire

// File: bench/boot_image_source.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Image source on the far side of the loader
// ----------------------------------------
module boot_image_source
(
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic byte_ready,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  logic [7:0] q[$];
  logic took;
  logic gap;

  // Idle at start with nothing offered
  initial
  begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
    gap = 1'b0;
  end

  // Hold each byte until taken; a slow source idles a cycle after each
  always @(posedge clk_sys)
  begin
    took = byte_valid && byte_ready;
    #1;
    if (took)
    begin
      void'(q.pop_front());
      gap = slow;
    end
    if (q.size() > 0 && !gap)
    begin
      byte_valid = 1'b1;
      byte_data = q[0]; // Words queued LSB first
    end
    else
    begin
      byte_valid = 1'b0;
      byte_data = ~byte_data; // Stale data must never look like a byte
      gap = 1'b0;
    end
  end
endmodule

`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("Error %s expected %0h seen %0h", nm, e, g); \
    end \
  end

module tb_top;
  logic clk_sys, rst, rst_n_pin, slow, byte_valid, byte_ready_ff;
  logic boot_strap_bit0, boot_strap_bit1, boot_strap_bit2;
  logic [31:0] security_reg, ack_chan_ff, crc_acc;
  logic [7:0] byte_data, ram_wdata_ff;
  logic gpio_pull_down_ff, core_reset_ff, boot_start_ff, otp_fetch_ff;
  logic ram_we_ff, send_ack_ff, run_ff, boot_error_ff;
  logic [15:0] fetch_addr_ff, ram_addr_ff, run_addr_ff;
  boot_seq_pkg::boot_sel_type boot_sel_ff;
  boot_seq_pkg::pll_cfg_type pll_cfg_ff;
  logic [15:0] got_addr [0:63];
  logic [7:0] got_data [0:63];
  logic [7:0] exp_data [0:63];
  int n_mismatch = 0;
  int checks_done = 0;
  int wcnt, sends;

  tile_boot_sequencer #(.ADDR_W(16)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .rst_n_pin(rst_n_pin), .boot_strap_bit0(boot_strap_bit0),
    .boot_strap_bit1(boot_strap_bit1), .boot_strap_bit2(boot_strap_bit2),
    .security_reg(security_reg), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_ready_ff(byte_ready_ff),
    .gpio_pull_down_ff(gpio_pull_down_ff), .core_reset_ff(core_reset_ff),
    .boot_start_ff(boot_start_ff), .boot_sel_ff(boot_sel_ff),
    .otp_fetch_ff(otp_fetch_ff), .fetch_addr_ff(fetch_addr_ff),
    .ram_we_ff(ram_we_ff), .ram_addr_ff(ram_addr_ff),
    .ram_wdata_ff(ram_wdata_ff), .ack_chan_ff(ack_chan_ff),
    .send_ack_ff(send_ack_ff), .run_ff(run_ff), .run_addr_ff(run_addr_ff),
    .boot_error_ff(boot_error_ff), .pll_cfg_ff(pll_cfg_ff));

  boot_image_source u_src (.clk_sys(clk_sys), .slow(slow),
    .byte_ready(byte_ready_ff), .byte_valid(byte_valid),
    .byte_data(byte_data));

  // ----------------------------------------
  // Clock, monitor and helpers
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Record the first 64 RAM writes and every acknowledge pulse
  always @(posedge clk_sys)
  begin
    if (ram_we_ff === 1'b1 && wcnt < 64)
    begin
      got_addr[wcnt] = ram_addr_ff;
      got_data[wcnt] = ram_wdata_ff;
      wcnt++;
    end
    if (send_ack_ff === 1'b1)
      sends++;
  end

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask

  // Bitwise reflected CRC step, kept apart from the design's own
  function automatic logic [31:0] crc_step(logic [31:0] c, logic [7:0] d);
    int i;
    c = c ^ {24'h000000, d};
    for (i = 0; i < 8; i++)
      c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
    return c;
  endfunction

  task automatic push_word(input logic [31:0] w);
    int i;
    for (i = 0; i < 4; i++)
    begin
      u_src.q.push_back(w[8*i +: 8]); // LSB first
      crc_acc = crc_step(crc_acc, w[8*i +: 8]);
    end
  endtask

  function automatic boot_seq_pkg::boot_sel_type exp_sel(logic [2:0] c);
    boot_seq_pkg::boot_sel_type s;
    s = '{boot_seq_pkg::SRC_CHAN_END0, boot_seq_pkg::SRC_CHAN_END0,
      8'h00, 1'b0};
    case (c)
      3'h0: s.tile0_src = boot_seq_pkg::SRC_QSPI_MASTER;
      3'h1: s.tile0_src = boot_seq_pkg::SRC_SPI_MASTER;
      3'h2: s.tile0_src = boot_seq_pkg::SRC_SPI_SLAVE;
      3'h3: s = '{boot_seq_pkg::SRC_SPI_SLAVE, boot_seq_pkg::SRC_SPI_SLAVE,
        8'h00, 1'b0};
      3'h4: s.links_en = 8'h01;
      3'h5: s = '{s.tile0_src, s.tile1_src, 8'hf0, 1'b1};
      3'h6: s = '{s.tile0_src, s.tile1_src, 8'h66, 1'b1};
      default: s = '{s.tile0_src, s.tile1_src, 8'h0f, 1'b1};
    endcase
    return s;
  endfunction

  // Full reset through both inputs, then wait for the loader to open
  task automatic boot(input logic [2:0] code, input logic sec);
    int k;
    rst = 1'b1;
    rst_n_pin = 1'b0;
    {boot_strap_bit2, boot_strap_bit1, boot_strap_bit0} = code;
    security_reg = sec ? 32'h00000020 : 32'h00000000;
    repeat (5) tick();
    rst = 1'b0;
    repeat (10) tick();
    `CHK("core_reset", 1'b1, core_reset_ff)
    `CHK("pull_down", 1'b1, gpio_pull_down_ff)
    `CHK("ready_in_reset", 1'b0, byte_ready_ff)
    `CHK("pll_cfg", {3'h1, 12'h03f, 6'h00}, pll_cfg_ff)
    rst_n_pin = 1'b1;
    for (k = 0; k < 4000 && byte_ready_ff !== 1'b1; k++)
      tick();
    `CHK("boot_delay", 1'b1, k >= 300 && k <= 3000)
    `CHK("boot_start", 1'b1, boot_start_ff)
    `CHK("core_released", 1'b0, core_reset_ff)
  endtask

  // Queue an image (mode 0 good check, 1 skip word, 2 bad) and await end
  task automatic send_image(input logic [31:0] ack, input bit use_ack,
    input int nw, input int mode, input logic exp_run);
    int i;
    wcnt = 0;
    sends = 0;
    if (use_ack)
      push_word(ack);
    crc_acc = 32'hffffffff;
    push_word(nw);
    for (i = 0; i < nw * 4; i++)
    begin
      exp_data[i] = 8'h5a ^ 8'(i * 37);
      u_src.q.push_back(exp_data[i]);
      crc_acc = crc_step(crc_acc, exp_data[i]);
    end
    crc_acc = ~crc_acc;
    if (mode == 1)
      crc_acc = 32'h0d15ab1e;
    if (mode == 2)
      crc_acc = crc_acc ^ 32'h00000100;
    push_word(crc_acc);
    for (i = 0; i < 3000 && run_ff !== 1'b1 && boot_error_ff !== 1'b1; i++)
      tick();
    repeat (4) tick();
    `CHK("run", exp_run, run_ff)
    `CHK("boot_error", ~exp_run, boot_error_ff)
    `CHK("run_addr", 16'h0000, run_addr_ff)
    `CHK("write_count", nw * 4, wcnt)
    for (i = 0; i < nw * 4; i++)
    begin
      `CHK("ram_addr", 16'(i), got_addr[i])
      `CHK("ram_data", exp_data[i], got_data[i])
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_straps();
    int c;
    for (c = 0; c < 8; c++)
    begin
      boot(3'(c), 1'b0);
      `CHK("boot_sel", exp_sel(3'(c)), boot_sel_ff)
    end
    {boot_strap_bit2, boot_strap_bit1, boot_strap_bit0} = 3'h0;
    repeat (20) tick();
    `CHK("sel_held", exp_sel(3'h7), boot_sel_ff)
    `CHK("pll_ratio", 16, ((pll_cfg_ff.feedback + 1) / 2) /
      ((pll_cfg_ff.ref_divider + 1) * (pll_cfg_ff.pll_output_divider + 1)))
    // VCO in MHz at both ends of the 9 to 25 MHz oscillator range
    `CHK("pll_vco", 1'b1, (9 * (pll_cfg_ff.feedback + 1) / 2 / (pll_cfg_ff.ref_divider + 1) >= 260) && (25 * (pll_cfg_ff.feedback + 1) / 2 / (pll_cfg_ff.ref_divider + 1) <= 1300))
  endtask

  task automatic t_secure();
    boot(3'h2, 1'b1);
    `CHK("t0_otp", boot_seq_pkg::SRC_OTP, boot_sel_ff.tile0_src)
    `CHK("t1_otp", boot_seq_pkg::SRC_OTP, boot_sel_ff.tile1_src)
    `CHK("otp_fetch", 1'b1, otp_fetch_ff)
    `CHK("fetch_addr", 16'h0000, fetch_addr_ff)
  endtask

  task automatic t_images();
    slow = 1'b0;
    boot(3'h1, 1'b0);
    send_image(32'h0, 0, 3, 0, 1'b1); // Good check word
    slow = 1'b1;
    boot(3'h1, 1'b0);
    send_image(32'h0, 0, 0, 1, 1'b1); // Empty program, skip word
    slow = 1'b0;
    boot(3'h0, 1'b0);
    send_image(32'h0, 0, 2, 2, 1'b0); // Corrupt check word
  endtask

  task automatic t_link();
    boot(3'h4, 1'b0);
    send_image(32'h00001234, 1, 1, 0, 1'b1);
    `CHK("ack_chan", 32'h00001234, ack_chan_ff)
    `CHK("ack_sent", 1, sends)
    slow = 1'b1;
    boot(3'h7, 1'b0);
    send_image(32'h0000ff02, 1, 1, 1, 1'b1);
    `CHK("null_ack", 0, sends)
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence; the watchdog allows about five times the expected run
  initial
  begin
    {rst, rst_n_pin, slow, boot_strap_bit0} = 4'b1000;
    {boot_strap_bit1, boot_strap_bit2} = 2'b00;
    security_reg = 32'h00000000;
    wcnt = 0;
    sends = 0;
    t_straps();
    t_secure();
    t_images();
    t_link();
    tally_and_finish();
  end

  initial
  begin
    #(25000 * 50);
    n_mismatch++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
